// file: logic/perf_event_counters_params.svh
`ifndef PERF_EVENT_COUNTERS_PARAMS_SVH
`define PERF_EVENT_COUNTERS_PARAMS_SVH

// Counter geometry
`define NUM_COUNTERS      4
`define CNT_W             32
`define CNT_RESET         32'h0000_0000
`define CNT_MAX           32'hffff_ffff
`define OVF_BIT           31
`define OVF_MIDPOINT      32'h8000_0000
`define MAX_ADD           3'h4

// Register port addressing: 0..3 privileged, 4..7 user alias
`define ADDR_W            3
`define ADDR_USER_BIT     2

// Event select encodings
`define EV_SEL_W          7
`define EV_NOTHING        7'h00
`define EV_PIPE_BASE      7'h01
`define EV_PIPE_END       7'h09
`define EV_CHAIN_BASE     7'h10
`define EV_CHAIN_END      7'h14
`define EV_THRESH         7'h20
`define NUM_PIPE          8

// Event attributes: bit per pipeline source, bit per counter
`define PIPE_FILTERABLE   8'h3f
`define PIPE_SPECULATIVE  8'hf0
`define THRESH_COUNTERS   4'h3

// Field widths
`define TIMEBASE_BIT_SELECT_W           5
`define THRESH_W          6
`define DURATION_W        16

`endif

// file: logic/perf_event_counters_pkg.sv
`include "perf_event_counters_params.svh"

package perf_event_counters_pkg;

   // One pipeline event source: committed and later-flushed occurrences
   typedef struct packed {
      logic [2:0] committed;
      logic [2:0] flushed;
   } pipe_event_t;

   typedef struct packed {
      logic                   condition_enable;
      logic                   exclude_supervisor;
      logic                   exclude_user;
      logic                   exclude_marked;
      logic                   exclude_unmarked;
      logic [`EV_SEL_W-1:0]   event_select;
      logic [`THRESH_W-1:0]   threshold;
   } local_control_a_t;

   typedef struct packed {
      logic                   freeze_all_counters;
      logic                   monitor_interrupt_enable;
      logic                   freeze_on_enabled_condition;
      logic                   timebase_event_enable;
      logic [`TIMEBASE_BIT_SELECT_W-1:0]    timebase_bit_select;
   } global_control_t;

   typedef struct packed {
      logic user_privilege_state;
      logic process_mark;
      logic external_interrupt_enable;
   } machine_state_t;

   typedef struct packed {
      logic                   rd;
      logic                   wr;
      logic [`ADDR_W-1:0]     addr;
      logic [`CNT_W-1:0]      wdata;
   } reg_req_t;

   typedef struct packed {
      logic [`NUM_COUNTERS-1:0][`CNT_W-1:0] count;
      logic [`NUM_COUNTERS-1:0]             rollover;
      logic                                 tb_prev;
      logic                                 tb_latched;
      logic                                 exception;
      logic                                 irq;
      logic                                 frozen;
      logic [`CNT_W-1:0]                    rdata;
      logic                                 rvalid;
   } state_t;

endpackage

// file: logic/counter_step.sv
`timescale 1ns/1ps
`default_nettype none
`include "perf_event_counters_params.svh"

module counter_step (
   // Current value and controls
   input  wire logic [`CNT_W-1:0] i_value,
   input  wire logic [2:0]        i_add,
   input  wire logic              i_hold,
   input  wire logic              i_wr,
   input  wire logic [`CNT_W-1:0] i_wdata,
   // Next value and carry out
   output logic [`CNT_W-1:0]      o_next,
   output logic                   o_rollover
);

   logic [`CNT_W:0] sum;

   // Software write beats freeze and counting; carry out feeds chained counters
   always_comb begin
      sum = {1'b0, i_value} + {30'h0, i_add};
      if (i_wr) begin
         o_next     = i_wdata;
         o_rollover = 1'b0;
      end else if (i_hold) begin
         o_next     = i_value;
         o_rollover = 1'b0;
      end else begin
         o_next     = sum[`CNT_W-1:0];
         o_rollover = sum[`CNT_W];
      end
   end

endmodule
`default_nettype wire

// file: logic/context_filter.sv
`timescale 1ns/1ps
`default_nettype none

module context_filter (
   // Filter selection
   input  wire logic i_filterable,
   input  wire logic i_exclude_supervisor,
   input  wire logic i_exclude_user,
   input  wire logic i_exclude_marked,
   input  wire logic i_exclude_unmarked,
   // Processor context
   input  wire logic i_user_privilege_state,
   input  wire logic i_process_mark,
   // Result
   output logic      o_allow
);

   logic priv_ok;
   logic mark_ok;

   // Both bits of a pair set leaves no matching state
   always_comb begin
      priv_ok = i_user_privilege_state ? !i_exclude_user : !i_exclude_supervisor;
      mark_ok = i_process_mark ? !i_exclude_marked : !i_exclude_unmarked;
      o_allow = !i_filterable || (priv_ok && mark_ok);
   end

endmodule
`default_nettype wire

// file: logic/perf_event_counters.sv
`timescale 1ns/1ps
`default_nettype none
`include "perf_event_counters_params.svh"

module perf_event_counters
   import perf_event_counters_pkg::*;
(
   // Clock and reset
   input  wire logic                          i_clk,
   input  wire logic                          i_nrst,
   // Special register move port
   input  wire reg_req_t                      i_reg_req,
   output logic [`CNT_W-1:0]                  o_reg_rdata,
   output logic                               o_reg_rvalid,
   // Controls
   input  wire global_control_t               i_global_control,
   input  wire local_control_a_t              i_local_control [`NUM_COUNTERS],
   input  wire machine_state_t                i_machine_state,
   // Event sources
   input  wire pipe_event_t                   i_pipe_event [`NUM_PIPE],
   input  wire logic                          i_duration_valid,
   input  wire logic [`DURATION_W-1:0]        i_duration_cycles,
   input  wire logic [`CNT_W-1:0]             i_timebase_lower,
   input  wire logic                          i_interrupt_taken,
   // Status
   output logic                               o_exception,
   output logic                               o_irq,
   output logic                               o_frozen,
   output logic [`NUM_COUNTERS-1:0]           o_overflow_indicator
);

   state_t                   state;
   state_t                   next_state;

   logic [`CNT_W-1:0]        step_next [`NUM_COUNTERS];
   logic [`NUM_COUNTERS-1:0] step_roll;
   logic [`NUM_COUNTERS-1:0] wr_hit;
   logic [`NUM_COUNTERS-1:0] ovf_cond;
   logic                     freeze;
   logic                     tb_bit;
   logic                     tb_rise;
   logic                     cond_any;
   logic                     exc;

   // Attribute masks as constants so a source or counter index can select a bit
   localparam logic [`NUM_PIPE-1:0]     pipe_filterable_mask  = `PIPE_FILTERABLE;
   localparam logic [`NUM_PIPE-1:0]     pipe_speculative_mask = `PIPE_SPECULATIVE;
   localparam logic [`NUM_COUNTERS-1:0] thresh_counter_mask   = `THRESH_COUNTERS;

   // Enabled conditions are taken from registered state to keep paths short
   always_comb begin
      for (int k = 0; k < `NUM_COUNTERS; k++) begin
         ovf_cond[k] = i_local_control[k].condition_enable && state.count[k][`OVF_BIT];
         wr_hit[k]   = i_reg_req.wr && !i_reg_req.addr[`ADDR_USER_BIT]
                       && (i_reg_req.addr[1:0] == 2'(k));
      end
      tb_bit   = i_timebase_lower[i_global_control.timebase_bit_select];
      tb_rise  = i_global_control.timebase_event_enable && tb_bit && !state.tb_prev;
      cond_any = (|ovf_cond) || state.tb_latched;
      freeze   = i_global_control.freeze_all_counters
                 || (i_global_control.freeze_on_enabled_condition && cond_any);
      exc      = i_global_control.monitor_interrupt_enable && cond_any;
   end

   // Per-counter event selection, filtering and stepping
   for (genvar i = 0; i < `NUM_COUNTERS; i++) begin : gen_ctr
      logic [2:0]  raw;
      logic [2:0]  add;
      logic        filterable;
      logic        allow;
      logic [2:0]  pidx;
      logic [3:0]  tot;
      logic [1:0]  cidx;
      pipe_event_t ev;

      // Unknown or unassigned selects count nothing
      always_comb begin
         raw        = 3'h0;
         filterable = 1'b0;
         pidx       = 3'(i_local_control[i].event_select - `EV_PIPE_BASE);
         cidx       = 2'(i_local_control[i].event_select - `EV_CHAIN_BASE);
         ev         = i_pipe_event[pidx];
         tot        = 4'h0;
         if (i_local_control[i].event_select >= `EV_PIPE_BASE
             && i_local_control[i].event_select < `EV_PIPE_END) begin
            // Flushed work only counts for speculative sources
            tot = {1'b0, ev.committed}
                  + (pipe_speculative_mask[pidx] ? {1'b0, ev.flushed} : 4'h0);
            raw = (tot > {1'b0, `MAX_ADD}) ? `MAX_ADD : tot[2:0];
            filterable = pipe_filterable_mask[pidx];
         end else if (i_local_control[i].event_select >= `EV_CHAIN_BASE
                      && i_local_control[i].event_select < `EV_CHAIN_END) begin
            raw = {2'h0, state.rollover[cidx]};
         end else if (i_local_control[i].event_select == `EV_THRESH
                      && thresh_counter_mask[i]) begin
            raw = {2'h0, i_duration_valid
                   && (i_duration_cycles > {10'h0, i_local_control[i].threshold})};
            filterable = 1'b1;
         end
         add = allow ? raw : 3'h0;
      end

      context_filter u_filter (
         .i_filterable           (filterable),
         .i_exclude_supervisor   (i_local_control[i].exclude_supervisor),
         .i_exclude_user         (i_local_control[i].exclude_user),
         .i_exclude_marked       (i_local_control[i].exclude_marked),
         .i_exclude_unmarked     (i_local_control[i].exclude_unmarked),
         .i_user_privilege_state (i_machine_state.user_privilege_state),
         .i_process_mark         (i_machine_state.process_mark),
         .o_allow                (allow)
      );

      counter_step u_step (
         .i_value    (state.count[i]),
         .i_add      (add),
         .i_hold     (freeze),
         .i_wr       (wr_hit[i]),
         .i_wdata    (i_reg_req.wdata),
         .o_next     (step_next[i]),
         .o_rollover (step_roll[i])
      );
   end

   // Next state
   always_comb begin
      next_state = state;
      for (int k = 0; k < `NUM_COUNTERS; k++) begin
         next_state.count[k] = step_next[k];
      end
      next_state.rollover = step_roll;
      next_state.tb_prev  = tb_bit;
      // A new rise wins over the clear from a taken interrupt
      if (tb_rise) begin
         next_state.tb_latched = 1'b1;
      end else if (i_interrupt_taken) begin
         next_state.tb_latched = 1'b0;
      end
      next_state.exception = exc;
      next_state.irq       = exc && i_machine_state.external_interrupt_enable;
      next_state.frozen    = freeze;
      // User alias addresses read the same storage; writes to them are dropped
      next_state.rvalid = i_reg_req.rd;
      if (i_reg_req.rd) begin
         next_state.rdata = state.count[i_reg_req.addr[1:0]];
      end
   end

   // State register
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   // Outputs straight from flops
   always_comb begin
      o_reg_rdata  = state.rdata;
      o_reg_rvalid = state.rvalid;
      o_exception  = state.exception;
      o_irq        = state.irq;
      o_frozen     = state.frozen;
      for (int k = 0; k < `NUM_COUNTERS; k++) begin
         o_overflow_indicator[k] = state.count[k][`OVF_BIT];
      end
   end

   // Checks
   reset_clears_counters_a : assert property (@(posedge i_clk) !i_nrst |=> state.count == '0)
      else $error("counters not cleared by reset");

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_nrst);

   freeze_holds_a : assert property (freeze && wr_hit == '0 |=> state.count == $past(state.count))
      else $error("frozen counter changed");

   write_lands_a : assert property (wr_hit[0] |=> state.count[0] == $past(i_reg_req.wdata))
      else $error("counter write lost");

   wrap_to_zero_a : assert property (!freeze && !wr_hit[1] && state.count[1] == `CNT_MAX
                                     && gen_ctr[1].add != 3'h0
                                     |=> state.count[1] < 32'h0000_0004 && state.rollover[1])
      else $error("counter did not wrap");

   step_bound_a : assert property (!wr_hit[2] |=> (state.count[2] - $past(state.count[2])) <= 32'h0000_0004)
      else $error("counter stepped by more than four");

   level_exception_a : assert property (i_global_control.monitor_interrupt_enable
                                        && ovf_cond[0] |=> o_exception)
      else $error("overflow condition did not signal");

   no_enable_quiet_a : assert property (!i_global_control.monitor_interrupt_enable |=> !o_exception)
      else $error("exception without interrupt enable");

   irq_gated_a : assert property (o_irq |-> o_exception && $past(i_machine_state.external_interrupt_enable))
      else $error("interrupt with external enable low");

   tb_latch_a : assert property (tb_rise ##1 (!i_interrupt_taken) [*2] |=> state.tb_latched)
      else $error("time-base condition not held");

   user_alias_a : assert property (i_reg_req.rd && i_reg_req.addr == 3'h4 && wr_hit == '0
                                   |=> o_reg_rvalid && o_reg_rdata == $past(state.count[0]))
      else $error("user alias mismatch");

   filter_block_a : assert property (gen_ctr[3].filterable && i_local_control[3].exclude_user
                                     && i_local_control[3].exclude_supervisor && !wr_hit[3]
                                     |=> state.count[3] == $past(state.count[3]))
      else $error("filtered counter counted");

   wrap_cov : cover property (state.rollover[0]);
   exception_cov : cover property (o_irq);
   tb_cov : cover property (tb_rise ##1 state.tb_latched);
   freeze_cov : cover property (o_frozen && !i_global_control.freeze_all_counters);

endmodule
`default_nettype wire

// file: verification/pipe_event_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "perf_event_counters_params.svh"

module pipe_event_model
   import perf_event_counters_pkg::*;
(
   // Clock and activity
   input  wire logic              i_clk,
   input  wire logic              i_active,
   // Pipeline occurrences toward the counters
   output pipe_event_t            o_pipe_event [`NUM_PIPE],
   output logic                   o_duration_valid,
   output logic [`DURATION_W-1:0] o_duration_cycles
);
   // Quiet sources at time zero
   initial begin
      foreach (o_pipe_event[i]) o_pipe_event[i] = '0;
      o_duration_valid = 1'b0;
      o_duration_cycles = '0;
   end

   // New occurrences each cycle; an idle pipeline reports no events at all
   always @(negedge i_clk) begin
      foreach (o_pipe_event[i]) begin
         o_pipe_event[i].committed <= i_active ? 3'($urandom_range(3)) : 3'h0;
         o_pipe_event[i].flushed <= i_active ? 3'($urandom_range(3)) : 3'h0;
      end
      o_duration_valid <= i_active & 1'($urandom_range(1));
      // Durations straddle the whole threshold range
      o_duration_cycles <= 16'($urandom_range(70));
   end
endmodule
`default_nettype wire

// file: verification/perf_event_counters_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "perf_event_counters_params.svh"

module perf_event_counters_tb
   import perf_event_counters_pkg::*;
;
   logic              i_clk, i_nrst, active, track, taken, dv, rvalid, exc, irq, frz;
   reg_req_t          rq;
   global_control_t   gc;
   local_control_a_t  lc [`NUM_COUNTERS];
   machine_state_t    ms;
   pipe_event_t       pe [`NUM_PIPE];
   logic [15:0]       dc;
   logic [31:0]       timebase_lower, rdata, v1, v2;
   logic [31:0]       exp_cnt [`NUM_COUNTERS];
   logic [3:0]        ovf;
   logic [6:0]        sel [4] = '{7'h01, 7'h20, 7'h06, 7'h20};
   int                n_errors, checks_done;

   perf_event_counters u_dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_reg_req(rq), .o_reg_rdata(rdata),
      .o_reg_rvalid(rvalid), .i_global_control(gc), .i_local_control(lc), .i_machine_state(ms),
      .i_pipe_event(pe), .i_duration_valid(dv), .i_duration_cycles(dc), .i_timebase_lower(timebase_lower),
      .i_interrupt_taken(taken), .o_exception(exc), .o_irq(irq), .o_frozen(frz), .o_overflow_indicator(ovf));
   pipe_event_model u_src (.i_clk(i_clk), .i_active(active), .o_pipe_event(pe),
      .o_duration_valid(dv), .o_duration_cycles(dc));

   initial begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end

   // Per-counter increment from what the core sees this cycle
   function automatic logic [31:0] add_of(input int n);
      int s, a, k;
      logic ok;
      s = lc[n].event_select;
      k = s - 1;
      ok = !((lc[n].exclude_supervisor && !ms.user_privilege_state) || (lc[n].exclude_user && ms.user_privilege_state)
         || (lc[n].exclude_marked && ms.process_mark) || (lc[n].exclude_unmarked && !ms.process_mark));
      a = 0;
      if (s >= 1 && s <= 8) begin
         a = pe[k].committed + (((`PIPE_SPECULATIVE >> k) & 1) ? pe[k].flushed : 0);
         if (a > 4) a = 4;
         if (((`PIPE_FILTERABLE >> k) & 1) && !ok) a = 0;
      end
      if (s == 'h20 && ((`THRESH_COUNTERS >> n) & 1) && dv && dc > lc[n].threshold && ok) a = 1;
      return 32'(a);
   endfunction

   // Reference counters follow every counting edge while tracked
   always @(posedge i_clk) begin
      if (track) begin
         for (int n = 0; n < 4; n++) exp_cnt[n] <= exp_cnt[n] + add_of(n);
      end
   end

   task automatic final_report;
      $display("comparisons %0d, mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] g, input logic [31:0] w);
      checks_done++;
      if (g !== w) begin
         n_errors++;
         $display("CHECK FAILED at %0t: got %h want %h", $time, g, w);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge i_clk);
   endtask

   task automatic wr(input int a, input logic [31:0] d);
      rq.wr = 1'b1;
      rq.addr = 3'(a);
      rq.wdata = d;
      @(negedge i_clk);
      rq.wr = 1'b0;
      // Let an edge pass so a following request never re-raises the strobe at once
      @(negedge i_clk);
   endtask

   // Read answer comes one cycle later; bounded in case it never does
   task automatic rd(input int a, output logic [31:0] v);
      int k;
      rq.rd = 1'b1;
      rq.addr = 3'(a);
      @(negedge i_clk);
      rq.rd = 1'b0;
      for (k = 0; k < 4 && rvalid !== 1'b1; k++) @(negedge i_clk);
      if (k == 4) begin
         n_errors++;
         $display("CHECK FAILED at %0t: no read answer", $time);
         final_report();
      end
      v = rdata;
      @(negedge i_clk);
   endtask

   task automatic rc(input int a, input logic [31:0] w);
      logic [31:0] v;
      rd(a, v);
      check(v, w);
   endtask

   // Tracked burst of random pipeline traffic, then quiet
   task automatic burst(input int n);
      track = 1'b1;
      active = 1'b1;
      cyc(n);
      active = 1'b0;
      cyc(2);
      track = 1'b0;
      cyc(2);
   endtask

   initial begin
      void'($urandom(32'h7193));
      {active, track, taken, i_nrst} = '0;
      {rq, gc, ms, timebase_lower} = '0;
      foreach (lc[n]) lc[n] = '0;
      foreach (exp_cnt[n]) exp_cnt[n] = '0;
      n_errors = 0;
      checks_done = 0;
      cyc(8);
      i_nrst = 1'b1;
      check({exc, irq, frz, ovf}, 32'h0);
      for (int a = 0; a < 8; a++) rc(a, 32'h0);
      $display("test reset done");
      // Alias writes must be dropped
      for (int n = 0; n < 4; n++) begin
         exp_cnt[n] = $urandom() & 32'h7fff_ffff;
         wr(n, exp_cnt[n]);
         wr(n + 4, ~exp_cnt[n]);
      end
      for (int a = 0; a < 8; a++) rc(a, exp_cnt[a % 4]);
      $display("test write_alias done");
      // Random filters, contexts, sources and thresholds
      for (int r = 0; r < 4; r++) begin
         ms = 3'($urandom());
         for (int n = 0; n < 4; n++) begin
            lc[n] = '0;
            {lc[n].exclude_supervisor, lc[n].exclude_user, lc[n].exclude_marked, lc[n].exclude_unmarked} = 4'($urandom());
            lc[n].threshold = 6'($urandom());
            // Counter 1 carries the threshold event except in round 3; counter 0 alternates to a speculative source
            lc[n].event_select = (n == 2 && r % 2) ? 7'h20 : (n == 1 && r == 3) ? 7'h7f
                               : (n == 0 && r % 2) ? 7'h08 : sel[n];
         end
         burst(50);
         for (int n = 0; n < 4; n++) rc(n, exp_cnt[n]);
      end
      $display("test counting done");
      // Freeze first, load while frozen, release last
      gc.freeze_all_counters = 1'b1;
      active = 1'b1;
      cyc(3);
      wr(2, 32'h0000_0042);
      cyc(20);
      rc(2, 32'h0000_0042);
      rc(1, exp_cnt[1]);
      check(frz, 1'b1);
      active = 1'b0;
      cyc(2);
      gc.freeze_all_counters = 1'b0;
      exp_cnt[2] = 32'h0000_0042;
      $display("test freeze_all done");
      // Cross the midpoint with the condition enabled
      ms = '0;
      lc[0] = '0;
      lc[0].event_select = 7'h01;
      lc[0].condition_enable = 1'b1;
      gc.monitor_interrupt_enable = 1'b1;
      wr(0, 32'h7fff_ff00);
      exp_cnt[0] = 32'h7fff_ff00;
      burst(250);
      rc(0, exp_cnt[0]);
      check(ovf[0], exp_cnt[0][31]);
      check(exc, exp_cnt[0][31]);
      check(irq, 1'b0);
      ms.external_interrupt_enable = 1'b1;
      cyc(3);
      check(irq, exp_cnt[0][31]);
      gc.monitor_interrupt_enable = 1'b0;
      cyc(3);
      check({exc, irq}, 2'b00);
      gc.monitor_interrupt_enable = 1'b1;
      lc[0].condition_enable = 1'b0;
      cyc(3);
      check({exc, frz}, 2'b00);
      $display("test overflow done");
      // Enabled overflow freezes everything
      lc[0].condition_enable = 1'b1;
      gc.freeze_on_enabled_condition = 1'b1;
      gc.monitor_interrupt_enable = 1'b0;
      active = 1'b1;
      cyc(3);
      check(frz, 1'b1);
      rd(0, v1);
      cyc(20);
      rd(0, v2);
      check(v2, v1);
      active = 1'b0;
      gc.freeze_on_enabled_condition = 1'b0;
      lc[0].condition_enable = 1'b0;
      cyc(2);
      $display("test freeze_condition done");
      // Wrap past all ones; chained counter takes the carry
      lc[1] = '0;
      lc[1].event_select = 7'h10;
      wr(1, 32'h0);
      wr(0, 32'hffff_ff00);
      exp_cnt[0] = 32'hffff_ff00;
      burst(250);
      rc(0, exp_cnt[0]);
      check(ovf[0], exp_cnt[0][31]);
      rc(1, 32'(exp_cnt[0] < 32'hffff_ff00));
      $display("test chain done");
      // Time-base rise latches until an interrupt is taken
      gc = '0;
      gc.monitor_interrupt_enable = 1'b1;
      gc.timebase_bit_select = 5'($urandom());
      timebase_lower[gc.timebase_bit_select] = 1'b1;
      cyc(3);
      check(exc, 1'b0);
      timebase_lower = '0;
      gc.timebase_event_enable = 1'b1;
      cyc(3);
      timebase_lower[gc.timebase_bit_select] = 1'b1;
      cyc(3);
      check(exc, 1'b1);
      timebase_lower = '0;
      cyc(3);
      check(exc, 1'b1);
      taken = 1'b1;
      cyc(1);
      taken = 1'b0;
      cyc(2);
      check(exc, 1'b0);
      $display("test timebase done");
      final_report();
   end
endmodule
`default_nettype wire
